// ===== verilog/spsc_pkg.sv
// constants and types for the sensor power and sleep control block
`default_nettype none
package spsc_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] MODE_IDX = 8'h1A;
   localparam logic [7:0] STATUS_IDX = 8'h1C;
   localparam logic [7:0] MODE_ADDR = {MODE_IDX[5:0], 2'b00};
   localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};
   // power mode control fields
   localparam int BIT_CHIP_RESET = 7;
   localparam int BIT_POWER_DOWN = 6;
   localparam int BIT_LED_SHUTTER = 3;
   localparam int BIT_SLEEP_EN = 2;
   localparam int BIT_SLEEP_MAN = 1;
   localparam int BIT_WAKEUP = 0;
   localparam logic [7:0] MODE_RESET_VAL = 8'h0C;
   localparam logic [7:0] MODE_WR_MASK = 8'hCF;
   localparam logic [2:0] SLEEP_FORCE_PAT = 3'h6;
   localparam logic [2:0] WAKE_FORCE_PAT = 3'h5;
   // status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_MOTION = 2;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned IDLE_TIME_MS = 1000;
   localparam int unsigned IDLE_CYCLES_DEF = IDLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned RESET_PULSE_CYCLES = 8;
   typedef enum logic [1:0]
   {
      ST_NORMAL = 2'b00,
      ST_SLEEP = 2'b01,
      ST_POWER_DOWN = 2'b10,
      ST_CHIP_RESET = 2'b11
   } spsc_state_e;
endpackage
`default_nettype wire

// ===== verilog/spsc_idle_timer.sv
// idle timer that flags a long stretch without motion
`timescale 1ns/1ps
`default_nettype none
module spsc_idle_timer
#(
   parameter int unsigned IDLE_CYCLES = 25000000
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic count_en,
   input wire logic motion,
   output logic expired
);
   localparam int CNT_W = $clog2(IDLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(IDLE_CYCLES - 1);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic expired_reg;
   logic expired_next;

   always_comb
   begin
      cnt_next = cnt_reg;
      if (!count_en || motion)
      begin
         cnt_next = '0;
      end
      else if (cnt_reg != LAST)
      begin
         cnt_next = cnt_reg + CNT_W'(1);
      end
      expired_next = count_en && !motion && (cnt_next == LAST);
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_reg <= '0;
         expired_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         expired_reg <= expired_next;
      end
   end

   assign expired = expired_reg;

   idle_clear_a: assert property (@(posedge clk) disable iff (reset)
      motion |=> !expired) else $error("idle flag set despite motion");
endmodule
`default_nettype wire

// ===== verilog/spsc_apb_slave.sv
// apb slave front end with zero wait states
`timescale 1ns/1ps
`default_nettype none
module spsc_apb_slave
   import spsc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] mode_rd,
   input wire logic [7:0] status_rd,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mode_wr
);
   logic setup;
   logic hit_mode;
   logic hit_stat;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pready_reg;
   logic pready_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic mode_hit_reg;
   logic mode_hit_next;

   always_comb
   begin
      setup = psel && !penable;
      hit_mode = 1'b0;
      hit_stat = 1'b0;
      if (paddr == MODE_ADDR)
      begin
         hit_mode = 1'b1;
      end
      else if (paddr == STATUS_ADDR)
      begin
         hit_stat = 1'b1;
      end
      pready_next = setup;
      pslverr_next = setup && !hit_mode && !hit_stat;
      mode_hit_next = setup && hit_mode;
      prdata_next = '0;
      if (setup && !pwrite && hit_mode)
      begin
         prdata_next = {24'h000000, mode_rd};
      end
      else if (setup && !pwrite && hit_stat)
      begin
         prdata_next = {24'h000000, status_rd};
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         mode_hit_reg <= 1'b0;
      end
      else
      begin
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         mode_hit_reg <= mode_hit_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign mode_wr = psel && penable && pwrite && pready_reg && mode_hit_reg;

   access_ready_a: assert property (@(posedge clk) disable iff (reset)
      psel && !penable |=> pready) else $error("no ready in access phase");
endmodule
`default_nettype wire

// ===== verilog/spsc_power_ctrl.sv
// sensor power, sleep and reset control with an apb register port
//
// What this block does
// - an 8-bit power mode control register sits at index 1A and returns to defaults on reset.
// - bits 2..0 read 0xx disable sleep, 110 force sleep entry and 101 force wakeup.
// - with sleep enabled, one second without motion in normal mode enters sleep.
// - sleep lasts until motion is seen, a wakeup is requested, the sleep enable bit is cleared, or bit 6 or 7 requests power-down or chip reset.
// - a manual sleep or wakeup bit written to one clears itself afterwards.
// - the sleep enable bit resets to one and writes turn automatic sleep off or on.
// - writing 110 to bits 2..0 in normal mode, with bits 7 and 6 clear, enters sleep on the next clock and the manual sleep bit clears.
`timescale 1ns/1ps
`default_nettype none
module spsc_power_ctrl
   import spsc_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = IDLE_CYCLES_DEF
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic motion_detected,
   output logic sleep_active,
   output logic power_down_request,
   output logic chip_reset_request,
   output logic led_shutter_enable
);
   localparam int RST_W = $clog2(RESET_PULSE_CYCLES + 1);
   localparam logic [RST_W-1:0] RST_LAST = RST_W'(RESET_PULSE_CYCLES - 1);

   logic [7:0] mode_reg;
   logic [7:0] mode_next;
   spsc_state_e state_reg;
   spsc_state_e state_next;
   logic [RST_W-1:0] rst_cnt_reg;
   logic [RST_W-1:0] rst_cnt_next;
   logic sleep_active_reg;
   logic sleep_active_next;
   logic power_down_reg;
   logic power_down_next;
   logic chip_reset_reg;
   logic chip_reset_next;
   logic led_shutter_reg;
   logic led_shutter_next;

   logic mode_wr;
   logic [7:0] status_rd;
   logic idle_expired;
   logic sleep_en;
   logic force_sleep;
   logic force_wake;
   logic reset_req;
   logic pd_req;
   logic idle_count_en;

   // register port
   spsc_apb_slave u_apb
   (
      .clk(clk),
      .reset(reset),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .mode_rd(mode_reg),
      .status_rd(status_rd),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .mode_wr(mode_wr)
   );

   // idle time measurement for automatic sleep
   spsc_idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) u_idle
   (
      .clk(clk),
      .reset(reset),
      .count_en(idle_count_en),
      .motion(motion_detected),
      .expired(idle_expired)
   );

   // field decode
   always_comb
   begin
      sleep_en = mode_reg[BIT_SLEEP_EN];
      force_sleep = (mode_reg[2:0] == SLEEP_FORCE_PAT);
      force_wake = (mode_reg[2:0] == WAKE_FORCE_PAT);
      reset_req = mode_reg[BIT_CHIP_RESET];
      pd_req = mode_reg[BIT_POWER_DOWN];
      idle_count_en = (state_reg == ST_NORMAL) && sleep_en;
      status_rd = '0;
      status_rd[STAT_STATE_LSB +: 2] = state_reg;
      status_rd[STAT_MOTION] = motion_detected;
   end

   // mode register and power state sequencing
   always_comb
   begin
      mode_next = mode_reg;
      state_next = state_reg;
      rst_cnt_next = '0;
      // request bits fall back to zero once the sequencer has seen them
      mode_next[BIT_SLEEP_MAN] = 1'b0;
      mode_next[BIT_WAKEUP] = 1'b0;
      case (state_reg)
         ST_NORMAL:
         begin
            if (reset_req)
            begin
               state_next = ST_CHIP_RESET;
            end
            else if (pd_req)
            begin
               state_next = ST_POWER_DOWN;
            end
            else if (force_sleep)
            begin
               state_next = ST_SLEEP;
            end
            else if (sleep_en && idle_expired)
            begin
               state_next = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (reset_req)
            begin
               state_next = ST_CHIP_RESET;
            end
            else if (pd_req)
            begin
               state_next = ST_POWER_DOWN;
            end
            else if (!sleep_en || motion_detected || force_wake)
            begin
               state_next = ST_NORMAL;
            end
         end
         ST_POWER_DOWN:
         begin
            if (reset_req)
            begin
               state_next = ST_CHIP_RESET;
            end
            else if (!pd_req)
            begin
               state_next = ST_NORMAL;
            end
         end
         ST_CHIP_RESET:
         begin
            rst_cnt_next = rst_cnt_reg + RST_W'(1);
            if (rst_cnt_reg == RST_LAST)
            begin
               rst_cnt_next = '0;
               state_next = ST_NORMAL;
               mode_next = MODE_RESET_VAL;
            end
         end
         default:
         begin
            state_next = ST_NORMAL;
         end
      endcase
      // a fresh write wins over the self-clear; reserved bits are dropped
      if (mode_wr && (state_reg != ST_CHIP_RESET))
      begin
         mode_next = pwdata[7:0] & MODE_WR_MASK;
      end
      sleep_active_next = (state_next == ST_SLEEP);
      power_down_next = (state_next == ST_POWER_DOWN);
      chip_reset_next = (state_next == ST_CHIP_RESET);
      led_shutter_next = mode_next[BIT_LED_SHUTTER] && !power_down_next;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         mode_reg <= MODE_RESET_VAL;
         state_reg <= ST_NORMAL;
         rst_cnt_reg <= '0;
         sleep_active_reg <= 1'b0;
         power_down_reg <= 1'b0;
         chip_reset_reg <= 1'b0;
         led_shutter_reg <= MODE_RESET_VAL[BIT_LED_SHUTTER];
      end
      else
      begin
         mode_reg <= mode_next;
         state_reg <= state_next;
         rst_cnt_reg <= rst_cnt_next;
         sleep_active_reg <= sleep_active_next;
         power_down_reg <= power_down_next;
         chip_reset_reg <= chip_reset_next;
         led_shutter_reg <= led_shutter_next;
      end
   end

   assign sleep_active = sleep_active_reg;
   assign power_down_request = power_down_reg;
   assign chip_reset_request = chip_reset_reg;
   assign led_shutter_enable = led_shutter_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   reserved_zero_a: assert property (
      mode_reg[5:4] == 2'b00) else $error("reserved mode bits not zero");

   force_sleep_a: assert property (
      state_reg == ST_NORMAL && force_sleep && !reset_req && !pd_req
      |=> sleep_active && !mode_reg[BIT_SLEEP_MAN])
      else $error("manual sleep not taken");

   self_clear_a: assert property (
      (mode_reg[BIT_SLEEP_MAN] || mode_reg[BIT_WAKEUP]) && !mode_wr
      |=> !mode_reg[BIT_SLEEP_MAN] && !mode_reg[BIT_WAKEUP])
      else $error("request bit did not clear");

   auto_sleep_a: assert property (
      state_reg == ST_NORMAL && sleep_en && idle_expired && !reset_req && !pd_req
      |=> state_reg == ST_SLEEP) else $error("idle sleep not entered");

   sleep_hold_a: assert property (
      state_reg == ST_SLEEP && sleep_en && !motion_detected && !force_wake
      && !reset_req && !pd_req |=> state_reg == ST_SLEEP)
      else $error("sleep left without cause");

   motion_wake_a: assert property (
      state_reg == ST_SLEEP && (motion_detected || force_wake)
      && !reset_req && !pd_req |=> state_reg == ST_NORMAL ##1 !sleep_active)
      else $error("wakeup not taken");

   sleep_disable_a: assert property (
      state_reg == ST_SLEEP && !sleep_en && !reset_req && !pd_req
      |=> state_reg == ST_NORMAL) else $error("disabled sleep kept");

   reset_pulse_a: assert property (
      $rose(chip_reset_request) |-> chip_reset_request [*8] ##1 !chip_reset_request
      && mode_reg == MODE_RESET_VAL) else $error("chip reset pulse wrong");

   power_down_a: assert property (
      state_reg != ST_CHIP_RESET && pd_req && !reset_req
      |=> power_down_request && !led_shutter_enable)
      else $error("power down not entered");

   write_default_a: assert property (
      mode_wr && state_reg != ST_CHIP_RESET
      |=> mode_reg == $past(pwdata[7:0] & MODE_WR_MASK))
      else $error("mode write lost");

   power_exit_a: assert property (
      state_reg == ST_POWER_DOWN && !pd_req && !reset_req
      |=> !power_down_request && state_reg == ST_NORMAL)
      else $error("power down not left");

   reset_entry_a: assert property (
      reset_req && state_reg != ST_CHIP_RESET
      |=> chip_reset_request && !sleep_active && !power_down_request)
      else $error("chip reset not entered");

   reset_lockout_a: assert property (
      state_reg == ST_CHIP_RESET && rst_cnt_reg != RST_LAST
      |=> $stable(mode_reg[BIT_CHIP_RESET:BIT_SLEEP_EN]))
      else $error("mode changed during chip reset");

   led_follow_a: assert property (
      led_shutter_enable == (mode_reg[BIT_LED_SHUTTER] && !power_down_request))
      else $error("led shutter enable wrong");

   one_state_a: assert property (
      $onehot0({sleep_active, power_down_request, chip_reset_request}))
      else $error("more than one power state shown");

   normal_hold_a: assert property (
      state_reg == ST_NORMAL && !idle_expired && !force_sleep && !reset_req && !pd_req
      |=> state_reg == ST_NORMAL && !sleep_active)
      else $error("sleep entered too early");

   sleep_off_a: assert property (
      !sleep_en |=> !sleep_active)
      else $error("sleep while disabled");

   wake_idle_a: assert property (
      state_reg == ST_NORMAL && force_wake && !idle_expired && !reset_req && !pd_req
      |=> state_reg == ST_NORMAL && !mode_reg[BIT_WAKEUP])
      else $error("wakeup in normal mode misused");

   sleep_entry_a: assert property (
      $rose(sleep_active) |-> $past(state_reg) == ST_NORMAL
      && state_reg == ST_SLEEP)
      else $error("sleep entered from wrong state");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking testbench for the sensor power and sleep control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import spsc_pkg::*;
;
   localparam int IDLE = 20;
   logic clk, reset, psel, penable, pwrite, motion_detected;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, sleep_active, power_down_request, chip_reset_request;
   logic led_shutter_enable, err;
   int n_mismatch, tests_run, cnt;

   spsc_power_ctrl #(.IDLE_CYCLES(IDLE)) u_spsc_power_ctrl (.clk(clk), .reset(reset),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .motion_detected(motion_detected),
      .sleep_active(sleep_active), .power_down_request(power_down_request),
      .chip_reset_request(chip_reset_request), .led_shutter_enable(led_shutter_enable));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic complete_run();
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic timed_out();
      n_mismatch++;
      $display("ERROR at %0t: wait expired, got %h expected %h", $time, 1'b0, 1'b1);
      complete_run();
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1)
      begin
         timed_out();
      end
      else
      begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [7:0] d);
      apb(MODE_ADDR, 1'b1, {24'h000000, d});
   endtask

   task automatic rd_mode(input logic [7:0] exp);
      apb(MODE_ADDR, 1'b0, 32'h00000000);
      chk(rd, {24'h000000, exp});
      chk(err, 1'b0);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic t_reset();
      rd_mode(MODE_RESET_VAL);
      chk(sleep_active, 1'b0);
      chk(power_down_request, 1'b0);
      chk(chip_reset_request, 1'b0);
      chk(led_shutter_enable, 1'b1);
      $display("test reset defaults done");
   endtask

   task automatic t_fields();
      wr(8'h3C);
      rd_mode(8'h0C);
      wr(8'h04);
      wait_n(3);
      chk(led_shutter_enable, 1'b0);
      rd_mode(8'h04);
      wr(8'h0C);
      wait_n(3);
      chk(led_shutter_enable, 1'b1);
      wr(8'h0D);
      rd_mode(8'h0C);
      chk(sleep_active, 1'b0);
      $display("test field access done");
   endtask

   task automatic t_force();
      motion_detected <= 1'b0;
      wr(8'h0E);
      wait_n(3);
      chk(sleep_active, 1'b1);
      rd_mode(8'h0C);
      wait_n(3 * IDLE);
      chk(sleep_active, 1'b1);
      apb(STATUS_ADDR, 1'b0, 32'h00000000);
      chk(rd, 32'h00000001);
      wr(8'h0D);
      wait_n(3);
      chk(sleep_active, 1'b0);
      rd_mode(8'h0C);
      wr(8'h0E);
      wait_n(3);
      chk(sleep_active, 1'b1);
      wr(8'h08);
      wait_n(3);
      chk(sleep_active, 1'b0);
      wr(8'h0C);
      motion_detected <= 1'b1;
      $display("test forced sleep and wakeup done");
   endtask

   task automatic t_auto();
      wr(8'h08);
      motion_detected <= 1'b0;
      wait_n(3 * IDLE);
      chk(sleep_active, 1'b0);
      motion_detected <= 1'b1;
      wr(8'h0C);
      @(posedge clk);
      motion_detected <= 1'b0;
      cnt = 0;
      while (sleep_active !== 1'b1 && cnt < 4 * IDLE)
      begin
         @(posedge clk);
         cnt++;
      end
      if (sleep_active !== 1'b1)
      begin
         timed_out();
      end
      else
      begin
         chk(cnt >= IDLE, 1'b1);
         chk(cnt <= IDLE + 2, 1'b1);
      end
      wait_n(5);
      chk(sleep_active, 1'b1);
      motion_detected <= 1'b1;
      wait_n(3);
      chk(sleep_active, 1'b0);
      $display("test automatic sleep done");
   endtask

   task automatic t_pd();
      wr(8'h4C);
      wait_n(3);
      chk(power_down_request, 1'b1);
      chk(led_shutter_enable, 1'b0);
      apb(STATUS_ADDR, 1'b0, 32'h00000000);
      chk(rd, 32'h00000006);
      wr(8'h0C);
      wait_n(3);
      chk(power_down_request, 1'b0);
      $display("test power-down done");
   endtask

   task automatic t_chip();
      wr(8'h8C);
      cnt = 0;
      repeat (40)
      begin
         @(posedge clk);
         if (chip_reset_request === 1'b1)
            cnt++;
      end
      chk(cnt, RESET_PULSE_CYCLES);
      rd_mode(MODE_RESET_VAL);
      $display("test chip reset done");
   endtask

   task automatic t_err();
      apb(8'h10, 1'b1, 32'h00000000);
      chk(err, 1'b1);
      apb(8'h10, 1'b0, 32'h00000000);
      chk(err, 1'b1);
      chk(rd, 32'h00000000);
      rd_mode(8'h0C);
      $display("test unmapped address done");
   endtask

   task automatic t_rst2();
      wr(8'h40);
      wait_n(3);
      chk(power_down_request, 1'b1);
      reset <= 1'b1;
      wait_n(2);
      chk(power_down_request, 1'b0);
      chk(led_shutter_enable, 1'b1);
      reset <= 1'b0;
      t_reset();
      $display("test reset in mid-run done");
   endtask

   initial
   begin
      n_mismatch = 0;
      tests_run = 0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      motion_detected = 1'b1;
      wait_n(6);
      reset <= 1'b0;
      t_reset();
      t_fields();
      t_force();
      t_auto();
      t_pd();
      t_chip();
      t_err();
      t_rst2();
      complete_run();
   end
endmodule
`default_nettype wire
